// ===== design/pic_pkg.sv
// Package of constants for the prioritized interrupt controller
`default_nettype none
package pic_pkg;
  localparam int NUM_SRC = 16;
  localparam logic [7:0] ADDR_ENABLE_LOW = 8'h3a;
  localparam logic [7:0] ADDR_ENABLE_HIGH = 8'h3b;
  localparam logic [7:0] ADDR_LATCH_LOW = 8'h3c;
  localparam logic [7:0] ADDR_LATCH_HIGH = 8'h3d;
  localparam int IDX_RESET = 0;
  localparam int IDX_SOFTWARE = 1;
  localparam int IDX_WATCHDOG = 2;
  localparam int IDX_EXT0 = 3;
  localparam int IDX_FIRST_EF = 4;
  localparam int BIT_MASTER = 0;
  localparam logic [15:0] VECTOR_TOP = 16'hfffe;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  // Bits 15..2 hold latches; 0 and 1 read zero
  localparam logic [15:0] LATCH_IMPL = 16'hfffc;
  // Bits 15..4 are source enables, bit 0 the master flag
  localparam logic [15:0] ENABLE_IMPL = 16'hfff1;
  localparam int ACCEPT_CYCLES = 8;
  typedef enum logic [1:0] {
    PIC_IDLE = 2'b00,
    PIC_ACCEPT = 2'b01,
    PIC_VECTOR = 2'b11
  } pic_state_t;
endpackage
`default_nettype wire

// ===== design/pic_top.sv
// Prioritized interrupt controller: latches, enables, priority, acceptance sequence
`default_nettype none
module pic_top #(
  parameter int ACCEPT_LEN = pic_pkg::ACCEPT_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [15:0] src_req,
  input wire logic sw_trap,
  input wire logic ext0_pin_enable,
  input wire logic instr_last_cycle,
  input wire logic unmask_all_instr,
  input wire logic mask_all_instr,
  input wire logic maskable_return_instr,
  input wire logic pseudo_nmi_return_instr,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic irq_pending,
  output logic accept_busy,
  output logic vector_valid,
  output logic [15:0] vector_addr,
  output logic [3:0] accepted_src
);
  initial begin
    if (ACCEPT_LEN < 2 || ACCEPT_LEN > 255) $error("ACCEPT_LEN out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rstn = rst_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Source synchronisers; requests may come from pins
  logic [15:0] req_s1_r, req_s2_r, req_d_r;
  logic swt_s1_r, swt_s2_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_s1_r <= 16'h0000;
      req_s2_r <= 16'h0000;
      req_d_r <= 16'h0000;
    end else if (clk_en) begin
      req_s1_r <= src_req;
      req_s2_r <= req_s1_r;
      req_d_r <= req_s2_r;
    end
  end

  // Trap is a level, so it needs no edge stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      swt_s1_r <= 1'b0;
      swt_s2_r <= 1'b0;
    end else if (clk_en) begin
      swt_s1_r <= sw_trap;
      swt_s2_r <= swt_s1_r;
    end
  end
  // Rising edge of a request level is one event
  wire [15:0] req_edge = req_s2_r & ~req_d_r;
  logic [15:0] ext0_gate;
  always_comb begin
    ext0_gate = 16'hffff;
    ext0_gate[pic_pkg::IDX_EXT0] = ext0_pin_enable;
  end
  wire [15:0] req_set = req_edge & ext0_gate & pic_pkg::LATCH_IMPL;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] latch_r, latch_nxt;
  logic [15:0] enable_r, enable_nxt;
  logic nmi_busy_r, nmi_busy_nxt;
  logic saved_master_r, saved_master_nxt;
  pic_pkg::pic_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [3:0] win_r, win_nxt;
  logic [15:0] vector_r, vector_nxt;

  wire wr_en_lo = reg_wr && reg_addr == pic_pkg::ADDR_ENABLE_LOW;
  wire wr_en_hi = reg_wr && reg_addr == pic_pkg::ADDR_ENABLE_HIGH;
  wire wr_la_lo = reg_wr && reg_addr == pic_pkg::ADDR_LATCH_LOW;
  wire wr_la_hi = reg_wr && reg_addr == pic_pkg::ADDR_LATCH_HIGH;
  wire master = enable_r[pic_pkg::BIT_MASTER];

  ////////////////////////////////////////////////////////////////////////////
  // Priority selection
  function automatic logic [4:0] pick_first(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) r = {1'b0, i[3:0]};
    end
    return r;
  endfunction

  // Vector table grows downward two bytes per priority step
  function automatic logic [15:0] vector_of(input logic [3:0] src);
    return pic_pkg::VECTOR_TOP - {11'h000, src, 1'b0};
  endfunction

  logic [15:0] eligible;
  always_comb begin
    eligible = 16'h0000;
    if (!nmi_busy_r) begin
      eligible[pic_pkg::IDX_SOFTWARE] = swt_s2_r;
      eligible[pic_pkg::IDX_WATCHDOG] = latch_r[pic_pkg::IDX_WATCHDOG];
    end
    if (master) begin
      eligible[pic_pkg::IDX_EXT0] = latch_r[pic_pkg::IDX_EXT0];
      eligible[15:4] = latch_r[15:4] & enable_r[15:4];
    end
  end
  wire [4:0] pick = pick_first(eligible);
  wire any_eligible = ~pick[4];
  wire start_accept = state_r == pic_pkg::PIC_IDLE && instr_last_cycle && any_eligible;
  wire is_nmi_pick = pick[3:0] == 4'(pic_pkg::IDX_SOFTWARE) || pick[3:0] == 4'(pic_pkg::IDX_WATCHDOG);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    latch_nxt = latch_r;
    enable_nxt = enable_r;
    nmi_busy_nxt = nmi_busy_r;
    saved_master_nxt = saved_master_r;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    win_nxt = win_r;
    vector_nxt = vector_r;
    // Software writes; latch writes only clear bits written zero
    if (wr_la_lo) latch_nxt[7:0] = latch_nxt[7:0] & reg_wdata;
    if (wr_la_hi) latch_nxt[15:8] = latch_nxt[15:8] & reg_wdata;
    if (wr_en_lo) enable_nxt[7:0] = reg_wdata & pic_pkg::ENABLE_IMPL[7:0];
    if (wr_en_hi) enable_nxt[15:8] = reg_wdata;
    if (unmask_all_instr) enable_nxt[pic_pkg::BIT_MASTER] = 1'b1;
    if (mask_all_instr) enable_nxt[pic_pkg::BIT_MASTER] = 1'b0;
    if (maskable_return_instr) enable_nxt[pic_pkg::BIT_MASTER] = 1'b1;
    if (pseudo_nmi_return_instr) begin
      enable_nxt[pic_pkg::BIT_MASTER] = saved_master_r & enable_r[pic_pkg::BIT_MASTER] | saved_master_r;
      nmi_busy_nxt = 1'b0;
    end
    unique case (state_r)
      pic_pkg::PIC_IDLE: begin
        if (start_accept) begin
          state_nxt = pic_pkg::PIC_ACCEPT;
          cnt_nxt = 8'(ACCEPT_LEN - 1);
          win_nxt = pick[3:0];
          enable_nxt[pic_pkg::BIT_MASTER] = 1'b0;
          latch_nxt[pick[3:0]] = 1'b0;
          if (is_nmi_pick) begin
            nmi_busy_nxt = 1'b1;
            saved_master_nxt = master;
          end
        end
      end
      pic_pkg::PIC_ACCEPT: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          state_nxt = pic_pkg::PIC_VECTOR;
          vector_nxt = vector_of(win_r);
        end
      end
      pic_pkg::PIC_VECTOR: begin
        state_nxt = pic_pkg::PIC_IDLE;
      end
      default: state_nxt = pic_pkg::PIC_IDLE;
    endcase
    // A new event wins over any clear in the same cycle
    latch_nxt = (latch_nxt | req_set) & pic_pkg::LATCH_IMPL;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers; every one holds while clk_en is low
  // Kept apart so each flop group reads on its own
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_r <= pic_pkg::LATCH_RESET;
    end else if (clk_en) begin
      latch_r <= latch_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_r <= pic_pkg::ENABLE_RESET;
    end else if (clk_en) begin
      enable_r <= enable_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmi_busy_r <= 1'b0;
    end else if (clk_en) begin
      nmi_busy_r <= nmi_busy_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      saved_master_r <= 1'b0;
    end else if (clk_en) begin
      saved_master_r <= saved_master_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= pic_pkg::PIC_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 8'h00;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      win_r <= 4'h0;
    end else if (clk_en) begin
      win_r <= win_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vector_r <= pic_pkg::VECTOR_TOP;
    end else if (clk_en) begin
      vector_r <= vector_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path and outputs
  logic [7:0] rdata_r;
  wire [7:0] rd_mux = (reg_addr == pic_pkg::ADDR_ENABLE_LOW) ? enable_r[7:0] :
                      (reg_addr == pic_pkg::ADDR_ENABLE_HIGH) ? enable_r[15:8] :
                      (reg_addr == pic_pkg::ADDR_LATCH_LOW) ? latch_r[7:0] :
                      (reg_addr == pic_pkg::ADDR_LATCH_HIGH) ? latch_r[15:8] : 8'h00;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rdata_r <= 8'h00;
    else if (clk_en && reg_rd) rdata_r <= rd_mux;
  end
  assign reg_rdata = rdata_r;
  assign irq_pending = any_eligible;
  assign accept_busy = state_r != pic_pkg::PIC_IDLE;
  assign vector_valid = state_r == pic_pkg::PIC_VECTOR;
  assign vector_addr = vector_r;
  assign accepted_src = win_r;
endmodule
`default_nettype wire

// ===== testbench/pic_asserts.sv
// Port checker for the interrupt controller
`default_nettype none
module pic_asserts #(parameter int ACCEPT_LEN = 8) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic instr_last_cycle,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_pending,
  input wire logic accept_busy,
  input wire logic vector_valid,
  input wire logic [15:0] vector_addr,
  input wire logic [3:0] accepted_src
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Counter instead of a delay so the length follows the parameter
  logic [7:0] cnt_r;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) cnt_r <= 8'h00;
    else cnt_r <= (accept_busy && !vector_valid) ? cnt_r + 8'h01 : 8'h00;
  property p_lat; vector_valid |-> cnt_r == ACCEPT_LEN - 1; endproperty
  a_lat: assert property (p_lat) else $error("vector timing");
  property p_one; vector_valid |=> !vector_valid; endproperty
  a_one: assert property (p_one) else $error("vector pulse");
  property p_vec; vector_valid |-> vector_addr == 16'hfffe - {11'h000, accepted_src, 1'b0}; endproperty
  a_vec: assert property (p_vec) else $error("vector address");
  property p_last; $rose(accept_busy) |-> $past(instr_last_cycle); endproperty
  a_last: assert property (p_last) else $error("mid-instruction start");
  property p_pend; $rose(accept_busy) |-> $past(irq_pending); endproperty
  a_pend: assert property (p_pend) else $error("start without request");
  property p_unm; reg_rd && !(reg_addr inside {[8'h3a:8'h3d]}) |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_enl; reg_rd && reg_addr == 8'h3a |=> reg_rdata[3:1] == 3'h0; endproperty
  a_enl: assert property (p_enl) else $error("enable gap bits");
  property p_ll; reg_rd && reg_addr == 8'h3c |=> reg_rdata[1:0] == 2'h0; endproperty
  a_ll: assert property (p_ll) else $error("latch gap bits");
  c_sw: cover property (vector_valid && accepted_src == 4'h1);
  c_wd: cover property (vector_valid && accepted_src == 4'h2);
  c_low: cover property (vector_valid && accepted_src == 4'hf);
endmodule
`default_nettype wire

// ===== testbench/pic_cpu_model.sv
// CPU core stand-in: instruction boundaries and return instructions
`default_nettype none
module pic_cpu_model #(parameter int INSTR_LEN = 3) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic vector_valid,
  input wire logic [3:0] accepted_src,
  output logic instr_last_cycle,
  output logic maskable_return_instr,
  output logic pseudo_nmi_return_instr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ic_r;
  logic [4:0] svc_r;
  // Larger INSTR_LEN gives a slow core; routines never unmask inside a pseudo NMI
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {ic_r, svc_r, instr_last_cycle, maskable_return_instr, pseudo_nmi_return_instr} <= 12'h000;
    end else begin
      ic_r <= (ic_r == 4'(INSTR_LEN - 1)) ? 4'h0 : ic_r + 4'h1;
      instr_last_cycle <= ic_r == 4'h0;
      maskable_return_instr <= svc_r == 5'h01 && accepted_src > 4'h2;
      pseudo_nmi_return_instr <= svc_r == 5'h01 && accepted_src < 4'h3;
      svc_r <= vector_valid ? 5'h14 : svc_r - {4'h0, svc_r != 5'h00};
    end
  end
endmodule
`default_nettype wire

// ===== testbench/pic_tb_top.sv
// Self-checking bench for the interrupt controller
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module pic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, sw_trap = 1'b0, ext0_pin_enable = 1'b1, mask_all_instr = 1'b0;
  logic unmask_all_instr = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, instr_last_cycle, maskable_return_instr;
  logic pseudo_nmi_return_instr, irq_pending, accept_busy, vector_valid;
  logic [15:0] src_req = 16'h0000, vector_addr;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] accepted_src;
  int failures = 0, tests_run = 0;
  // Rows: write flag, address, write data, expected read
  logic [24:0] rows [7] = '{25'h03a0000, 25'h03b0000, 25'h03c0000, 25'h03d0000, 25'h13bffff, 25'h13afef0, 25'h1405a00};
  always #2 clk = ~clk;
  pic_top #(.ACCEPT_LEN(8)) DUT (.clk, .resetn, .clk_en, .src_req, .sw_trap, .ext0_pin_enable, .instr_last_cycle,
    .unmask_all_instr, .mask_all_instr, .maskable_return_instr, .pseudo_nmi_return_instr, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .irq_pending, .accept_busy, .vector_valid, .vector_addr, .accepted_src);
  pic_cpu_model u_cpu (.clk, .resetn, .vector_valid, .accepted_src, .instr_last_cycle, .maskable_return_instr,
    .pseudo_nmi_return_instr);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    `CHK(reg_rdata, e)
  endtask
  // Held long enough to pass the input synchronisers
  task automatic pulse(input logic [15:0] v);
    @(posedge clk);
    src_req <= v;
    repeat (4) @(posedge clk);
    src_req <= 16'h0000;
    repeat (4) @(posedge clk);
  endtask
  task automatic wait_vec(input logic [3:0] s);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (vector_valid !== 1'b1 && n < 200);
    `CHK(vector_valid, 1'b1)
    `CHK(accepted_src, s)
    `CHK(vector_addr, 16'hfffe - {11'h000, s, 1'b0})
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    clk_en <= 1'b0;
    wr(8'h3b, 8'h00);
    clk_en <= 1'b1;
    rd(8'h3b, 8'hff);
    ext0_pin_enable <= 1'b0;
    pulse(16'h8038);
    rd(8'h3c, 8'h30);
    rd(8'h3d, 8'h80);
    `CHK(irq_pending, 1'b0)
    wr(8'h3c, 8'hef);
    rd(8'h3c, 8'h20);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'h20);
    @(posedge clk) unmask_all_instr <= 1'b1;
    @(posedge clk) unmask_all_instr <= 1'b0;
    wait_vec(4'h5);
    rd(8'h3c, 8'h00);
    rd(8'h3a, 8'hf0);
    wait_vec(4'hf);
    repeat (30) @(posedge clk);
    sw_trap <= 1'b1;
    wait_vec(4'h1);
    sw_trap <= 1'b0;
    pulse(16'h0004);
    `CHK(irq_pending, 1'b0)
    wait_vec(4'h2);
    repeat (30) @(posedge clk);
    rd(8'h3a, 8'hf1);
    @(posedge clk) mask_all_instr <= 1'b1;
    @(posedge clk) mask_all_instr <= 1'b0;
    sw_trap <= 1'b1;
    wait_vec(4'h1);
    sw_trap <= 1'b0;
    repeat (30) @(posedge clk);
    rd(8'h3a, 8'hf0);
    end_of_test;
  end
endmodule
bind pic_top pic_asserts #(.ACCEPT_LEN(ACCEPT_LEN)) u_chk (.clk, .resetn, .instr_last_cycle, .reg_addr, .reg_rd,
  .reg_rdata, .irq_pending, .accept_busy, .vector_valid, .vector_addr, .accepted_src);
`default_nettype wire
